// ### bench/eebb_ctrl_bench.sv
// Self-checking bench of the EEPROM bit-bang control block
`include "eebb_regs.svh"
module eebb_ctrl_bench;
   timeunit 1ns;
   timeprecision 1ns;
   import eebb_pkg::*;
   logic ref_clk_in = 1'b0; // 20 MHz clock
   logic sys_rst_in = 1'b1; // Reset, high at start
   eebb_reg_req_t req = '0; // Register port request
   logic [31:0] rdata; // Read data
   eebb_pins_t pins; // Memory pins
   logic mem_do; // Memory data out
   logic fdis = 1'b0; // Function disable
   logic serial = 1'b0; // Serial flash attached
   logic present = 1'b1; // Memory answers the scan
   logic wen, erase, irq; // Flash and interrupt outputs
   int mismatches = 0;
   int compares = 0;
   int erases = 0; // Erase pulses seen
   logic [31:0] lfsr = 32'h606E; // Random source
   logic [31:0] v; // Last value read
   logic pend = 1'b0; // Read answer standing
   logic [31:0] exp_q[$]; // Expected read values
   logic [31:0] msk_q[$]; // Bits that count
   always #25 ref_clk_in = ~ref_clk_in;
   eebb_ctrl eebb_ctrl_i (.ref_clk_in(ref_clk_in), .sys_rst_in(sys_rst_in), .reg_req_in(req),
      .reg_rdata_out(rdata), .mem_pins_out(pins), .mem_do_in(mem_do),
      .function_disable_in(fdis), .flash_is_serial_in(serial), .flash_write_en_out(wen),
      .flash_erase_out(erase), .irq_out(irq));
   eebb_mem_model eebb_mem_model_i (.sk_in(pins.sk), .cs_in(pins.cs), .di_in(pins.di),
      .present_in(present), .do_out(mem_do));
   ////////////////////////////////////////////////////////////////////////////
   function automatic logic [31:0] rnd(input logic [31:0] s);
      rnd = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction
   task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
      compares++;
      if (g !== e) begin
         mismatches++;
         $display("unexpected %s: expected %h seen %h", n, e, g);
      end
   endtask
   task automatic note(input string t);
      $display("finished %s", t);
   endtask
   task automatic end_of_test();
      $display("compares %0d mismatches %0d", compares, mismatches);
      if (mismatches == 0 && compares > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask
   // One-cycle write strobe
   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      @(posedge ref_clk_in);
      req <= '{a, d, 1'b1, 1'b0};
      @(posedge ref_clk_in);
      req.wr <= 1'b0;
   endtask
   // One-cycle read strobe, expectation noted for the watcher
   task automatic rd(input logic [11:0] a, input logic [31:0] m, input logic [31:0] e);
      @(posedge ref_clk_in);
      req <= '{a, 32'h0, 1'b0, 1'b1};
      exp_q.push_back(e);
      msk_q.push_back(m);
      @(posedge ref_clk_in);
      req.rd <= 1'b0;
      #1 v = rdata;
   endtask
   // Bounded wait for a control bit
   task automatic poll(input int b);
      int n;
      n = 0;
      v = '0;
      while (v[b] !== 1'b1 && n < 200) begin
         rd(`EEBB_OFF_CTRL, 32'h0, 32'h0);
         repeat (8) @(posedge ref_clk_in);
         n++;
      end
      chk("control poll", 32'h1, {31'h0, v[b]});
   endtask
   // Reset for two cycles, first read at the first edge after release
   task automatic do_reset();
      sys_rst_in <= 1'b1;
      repeat (2) @(posedge ref_clk_in);
      sys_rst_in <= 1'b0;
      req <= '{`EEBB_OFF_CTRL, 32'h0, 1'b0, 1'b1};
      exp_q.push_back(32'h110);
      msk_q.push_back(32'h3F7);
      @(posedge ref_clk_in);
      req.rd <= 1'b0;
   endtask
   ////////////////////////////////////////////////////////////////////////////
   // Watcher: oldest note compared while the answer stands
   always @(posedge ref_clk_in) pend <= req.rd;
   always @(posedge ref_clk_in) if (erase === 1'b1) erases <= erases + 1;
   always @(negedge ref_clk_in) begin
      if (pend && exp_q.size() > 0) begin
         if (msk_q[0] != 0) chk("read data", exp_q[0], rdata & msk_q[0]);
         void'(exp_q.pop_front());
         void'(msk_q.pop_front());
      end
   end
   // Watchdog
   initial begin
      #(50 * 30000);
      mismatches++;
      end_of_test();
   end
   ////////////////////////////////////////////////////////////////////////////
   initial begin
      do_reset();
      poll(`EEBB_BIT_AUTORD);
      rd(`EEBB_OFF_CTRL, 32'h3F7, 32'h310);
      rd(`EEBB_OFF_IRQ_STAT, 32'h7, 32'h2);
      rd(12'h0FC, 32'hFFFFFFFF, 32'h0);
      wr(`EEBB_OFF_IRQ_EN, 32'h2);
      #1 chk("irq", 32'h1, {31'h0, irq});
      wr(`EEBB_OFF_IRQ_EN, 32'h0);
      #1 chk("irq", 32'h0, {31'h0, irq});
      wr(`EEBB_OFF_IRQ_EN, 32'h2);
      wr(`EEBB_OFF_IRQ_CLR, 32'h2);
      #1 chk("irq", 32'h0, {31'h0, irq});
      rd(`EEBB_OFF_IRQ_CLR, 32'hFFFFFFFF, 32'h0);
      note("scan and interrupt");
      wr(`EEBB_OFF_CTRL, 32'h40);
      poll(`EEBB_BIT_GNT);
      rd(`EEBB_OFF_IRQ_STAT, 32'h1, 32'h1);
      for (int i = 0; i < 8; i++) begin
         lfsr = rnd(lfsr);
         wr(`EEBB_OFF_CTRL, (lfsr & 32'h3FF) | 32'h40);
         @(posedge ref_clk_in);
         #1 chk("pins", {29'h0, lfsr[0], lfsr[1], lfsr[2]}, {29'h0, pins});
         rd(`EEBB_OFF_CTRL, 32'h3F7, {29'h0, lfsr[2:0]} | 32'h3D0);
      end
      wr(`EEBB_OFF_CTRL, 32'h0);
      rd(`EEBB_OFF_CTRL, 32'h3F7, 32'h310);
      #1 chk("pins", 32'h0, {29'h0, pins});
      note("direct access");
      wr(`EEBB_OFF_CTRL, 32'h20);
      rd(`EEBB_OFF_CTRL, 32'h30, 32'h10);
      wr(`EEBB_OFF_FLASH_ACC, 32'h80);
      wr(`EEBB_OFF_CTRL, 32'h20);
      rd(`EEBB_OFF_CTRL, 32'h30, 32'h20);
      chk("write enable", 32'h1, {31'h0, wen});
      wr(`EEBB_OFF_CTRL, 32'h30);
      rd(`EEBB_OFF_CTRL, 32'h30, 32'h20);
      wr(`EEBB_OFF_CTRL, 32'h0);
      wr(`EEBB_OFF_FLASH_ACC, 32'h80000080);
      rd(`EEBB_OFF_FLASH_ACC, 32'h80000080, 32'h80000080);
      chk("erase count", 32'h0, erases);
      chk("write enable", 32'h0, {31'h0, wen});
      wr(`EEBB_OFF_FLASH_ACC, 32'h80);
      serial <= 1'b1;
      wr(`EEBB_OFF_FLASH_ACC, 32'h80000080);
      rd(`EEBB_OFF_FLASH_ACC, 32'h80000000, 32'h0);
      chk("erase count", 32'h1, erases);
      wr(`EEBB_OFF_CTRL, 32'h20);
      wr(`EEBB_OFF_FLASH_ACC, 32'h80000080);
      rd(`EEBB_OFF_CTRL, 32'h30, 32'h20);
      chk("erase count", 32'h1, erases);
      note("flash control");
      wr(`EEBB_OFF_CTRL, 32'h47);
      poll(`EEBB_BIT_GNT);
      fdis <= 1'b1;
      rd(`EEBB_OFF_CTRL, 32'h80, 32'h0);
      #1 chk("pins", 32'h0, {29'h0, pins});
      @(posedge ref_clk_in);
      fdis <= 1'b0;
      wr(`EEBB_OFF_CTRL, 32'h40);
      repeat (20) @(posedge ref_clk_in);
      rd(`EEBB_OFF_CTRL, 32'h80, 32'h0);
      note("function disable");
      @(posedge ref_clk_in);
      present <= 1'b0;
      do_reset();
      poll(`EEBB_BIT_AUTORD);
      rd(`EEBB_OFF_CTRL, 32'h300, 32'h200);
      note("absent memory");
      repeat (2) @(posedge ref_clk_in);
      end_of_test();
   end
endmodule

bind eebb_ctrl eebb_ctrl_monitor eebb_ctrl_monitor_i (.ref_clk_in(ref_clk_in),
   .sys_rst_in(sys_rst_in), .reg_req_in(reg_req_in), .reg_rdata_out(reg_rdata_out),
   .mem_pins_out(mem_pins_out), .mem_do_in(mem_do_in),
   .function_disable_in(function_disable_in), .flash_is_serial_in(flash_is_serial_in),
   .flash_write_en_out(flash_write_en_out), .flash_erase_out(flash_erase_out),
   .irq_out(irq_out));

// ### bench/eebb_ctrl_monitor.sv
// Port checks of the EEPROM bit-bang control block
`include "eebb_regs.svh"
module eebb_ctrl_monitor (
   input wire logic ref_clk_in,
   input wire logic sys_rst_in,
   input eebb_pkg::eebb_reg_req_t reg_req_in,
   input wire logic [31:0] reg_rdata_out,
   input eebb_pkg::eebb_pins_t mem_pins_out,
   input wire logic mem_do_in,
   input wire logic function_disable_in,
   input wire logic flash_is_serial_in,
   input wire logic flash_write_en_out,
   input wire logic flash_erase_out,
   input wire logic irq_out
);
   timeunit 1ns;
   timeprecision 1ns;
   import eebb_pkg::*;
   logic rd_ctrl; // Control register read taken
   assign rd_ctrl = reg_req_in.rd && reg_req_in.addr == `EEBB_OFF_CTRL;
   default clocking @(posedge ref_clk_in); endclocking
   default disable iff (sys_rst_in);
   ////////////////////////////////////////////////////////////////////////////
   pins_reset_a: assert property ($fell(sys_rst_in) |-> mem_pins_out == 3'h0)
      else $error("pins not low after reset");
   wen_reset_a: assert property ($fell(sys_rst_in) |-> !flash_write_en_out)
      else $error("write enable high after reset");
   irq_reset_a: assert property ($fell(sys_rst_in) |-> !irq_out)
      else $error("interrupt high after reset");
   reset_image_a: assert property ($fell(sys_rst_in) && rd_ctrl |=>
      (reg_rdata_out & 32'h3F7) == 32'h110) else $error("bad control image after reset");
   do_sample_a: assert property (rd_ctrl && !$past(sys_rst_in) |=>
      reg_rdata_out[3] == $past(mem_do_in, 2)) else $error("data-out bit not sampled");
   disable_pins_a: assert property (function_disable_in |=> mem_pins_out == 3'h0)
      else $error("pins driven while disabled");
   erase_serial_a: assert property (flash_erase_out |-> $past(flash_is_serial_in))
      else $error("erase without serial flash");
   erase_pulse_a: assert property (flash_erase_out |=> !flash_erase_out)
      else $error("erase longer than one cycle");
   erase_wen_a: assert property (flash_erase_out |-> !flash_write_en_out)
      else $error("erase while writes enabled");
endmodule

// ### bench/eebb_mem_model.sv
// Behavioural serial memory that answers the power-up scan
`include "eebb_regs.svh"
module eebb_mem_model (
   input wire logic sk_in,
   input wire logic cs_in,
   input wire logic di_in,
   input wire logic present_in,
   output logic do_out
);
   timeunit 1ns;
   timeprecision 1ns;
   int cnt = 0; // Clock rises in this frame
   logic [15:0] word = 16'h4000; // Top two bits 01 mark a valid image
   logic [7:0] cmd = 8'h00; // Command bits seen
   initial do_out = 1'b1;
   ////////////////////////////////////////////////////////////////////////////
   // Frame start clears the bit count
   always @(posedge cs_in) cnt = 0;
   // Count clock rises while selected
   always @(posedge sk_in) if (cs_in) begin
      if (cnt < 8) cmd = {cmd[6:0], di_in}; // Command taken on rising clock
      cnt = cnt + 1;
   end
   // Output changes on the falling clock, released line keeps moving
   always @(negedge sk_in or negedge cs_in) begin
      if (!cs_in) do_out = ~do_out; // Not selected: no stale level
      else if (cnt == 8) do_out = ~(present_in && cmd == `EEBB_READ_CMD);
      else if (cnt > 8 && cnt < 25) do_out = word[24 - cnt];
   end
endmodule

// ### hw/eebb_auto_read.sv
// Automatic power-up read engine: presence scan and signature check
`include "eebb_regs.svh"
module eebb_auto_read (
   input wire logic ref_clk_in,
   input wire logic sys_rst_in,
   input wire logic halt_in,
   input wire logic mem_do_in,
   output eebb_pkg::eebb_pins_t pins_out,
   output logic busy_out,
   output logic done_out,
   output logic present_out,
   output logic sig_ok_out
);
   import eebb_pkg::*;

   eebb_ar_state_t state_reg; // Engine state
   logic [7:0] div_reg;       // Serial clock divider
   logic tick;                // Half-bit enable pulse
   logic phase_reg;           // 0 low half, 1 high half
   logic [4:0] bit_cnt_reg;   // Bits done in phase
   logic [7:0] cmd_sr_reg;    // Command shifter
   logic [15:0] data_sr_reg;  // Received word
   logic [15:0] word_next;    // Word with newest bit
   logic last_cmd;            // Last command bit
   logic last_data;           // Last data bit

   ////////////////////////////////////////////////////////////////////////////
   // Divider that paces the serial clock
   always_ff @(posedge ref_clk_in) begin
      if (sys_rst_in || state_reg == AR_DONE) begin
         div_reg <= 8'h00;
      end else if (div_reg == `EEBB_SK_DIV - 8'h01) begin
         div_reg <= 8'h00;
      end else begin
         div_reg <= div_reg + 8'h01;
      end
   end

   assign tick = (div_reg == `EEBB_SK_DIV - 8'h01) && (state_reg != AR_DONE);
   assign word_next = {data_sr_reg[14:0], mem_do_in};
   assign last_cmd = bit_cnt_reg == `EEBB_CMD_BITS - 5'h01;
   assign last_data = bit_cnt_reg == `EEBB_DATA_BITS - 5'h01;
   assign busy_out = state_reg != AR_DONE;

   ////////////////////////////////////////////////////////////////////////////
   // Scan sequence: command, acknowledge slot, signature word
   always_ff @(posedge ref_clk_in) begin
      done_out <= 1'b0;
      if (sys_rst_in) begin
         state_reg <= AR_START;
         phase_reg <= 1'b0;
         bit_cnt_reg <= 5'h00;
         cmd_sr_reg <= 8'h00;
         data_sr_reg <= 16'h0000;
         pins_out <= `EEBB_RST_PINS;
         present_out <= `EEBB_RST_PRES;
         sig_ok_out <= 1'b0;
      end else if (halt_in && state_reg != AR_DONE) begin
         // Function disabled: stop, release pins, report done
         state_reg <= AR_DONE;
         pins_out <= `EEBB_RST_PINS;
         done_out <= 1'b1;
      end else if (tick) begin
         case (state_reg)
            AR_START: begin
               pins_out.cs <= 1'b1;
               pins_out.sk <= 1'b0;
               cmd_sr_reg <= `EEBB_READ_CMD;
               bit_cnt_reg <= 5'h00;
               phase_reg <= 1'b0;
               state_reg <= AR_CMD;
            end
            AR_CMD: begin
               if (!phase_reg) begin
                  // Present next bit while clock low
                  pins_out.sk <= 1'b0;
                  pins_out.di <= cmd_sr_reg[7];
                  phase_reg <= 1'b1;
               end else begin
                  pins_out.sk <= 1'b1;
                  cmd_sr_reg <= {cmd_sr_reg[6:0], 1'b0};
                  phase_reg <= 1'b0;
                  bit_cnt_reg <= last_cmd ? 5'h00 : bit_cnt_reg + 5'h01;
                  if (last_cmd) begin
                     state_reg <= AR_ACK;
                  end
               end
            end
            AR_ACK: begin
               if (!phase_reg) begin
                  pins_out.sk <= 1'b0;
                  pins_out.di <= 1'b0;
                  phase_reg <= 1'b1;
               end else begin
                  // Active-low acknowledge means a memory answers
                  pins_out.sk <= 1'b1;
                  phase_reg <= 1'b0;
                  present_out <= ~mem_do_in;
                  if (mem_do_in) begin
                     state_reg <= AR_DONE;
                     pins_out <= `EEBB_RST_PINS;
                     done_out <= 1'b1;
                  end else begin
                     state_reg <= AR_DATA;
                  end
               end
            end
            AR_DATA: begin
               if (!phase_reg) begin
                  pins_out.sk <= 1'b0;
                  phase_reg <= 1'b1;
               end else begin
                  pins_out.sk <= 1'b1;
                  phase_reg <= 1'b0;
                  data_sr_reg <= word_next;
                  bit_cnt_reg <= bit_cnt_reg + 5'h01;
                  if (last_data) begin
                     // Done whether or not the signature is valid
                     sig_ok_out <= word_next[`EEBB_SIG_HI:`EEBB_SIG_LO] == `EEBB_SIG_VALID;
                     state_reg <= AR_DONE;
                     pins_out <= `EEBB_RST_PINS;
                     done_out <= 1'b1;
                  end
               end
            end
            AR_DONE: begin
               pins_out <= `EEBB_RST_PINS;
            end
            default: begin
               state_reg <= AR_DONE;
            end
         endcase
      end
   end

endmodule

// ### hw/eebb_ctrl.sv
// EEPROM bit-bang control: register file, grant arbitration, pin mux, interrupts
//
// Added by the designer: the plain strobed port and the register addresses.
`include "eebb_regs.svh"
module eebb_ctrl (
   input wire logic ref_clk_in,
   input wire logic sys_rst_in,
   input eebb_pkg::eebb_reg_req_t reg_req_in,
   output logic [31:0] reg_rdata_out,
   output eebb_pkg::eebb_pins_t mem_pins_out,
   input wire logic mem_do_in,
   input wire logic function_disable_in,
   input wire logic flash_is_serial_in,
   output logic flash_write_en_out,
   output logic flash_erase_out,
   output logic irq_out
);
   import eebb_pkg::*;

   ////////////////////////////////////////////////////////////////////////////
   // Declarations
   eebb_pins_t sw_pins_reg;        // Software pin bits
   eebb_pins_t eng_pins;           // Engine pin drive
   logic req_reg;                  // Access request
   logic gnt_reg;                  // Access grant
   logic gnt_next;                 // Grant next value
   logic do_sample_reg;            // Sampled data-out
   logic [1:0] fwe_reg;            // Flash write-enable field
   logic pres_reg;                 // Memory present flag
   logic autord_reg;               // Auto read done flag
   logic swacc_reg;                // Software access enable
   logic erase_reg;                // Erase bit
   logic erase_fire;               // Erase issued now
   logic dead_reg;                 // Access failed after disable
   logic eng_busy;                 // Engine owns the memory
   logic eng_done;                 // Engine finished pulse
   logic eng_present;              // Engine presence result
   logic [`EEBB_IRQ_W-1:0] irq_stat_reg; // Sticky events
   logic [`EEBB_IRQ_W-1:0] irq_en_reg;   // Event enables
   logic [`EEBB_IRQ_W-1:0] irq_event;    // Events this cycle
   logic [`EEBB_IRQ_W-1:0] irq_clr;      // Clear mask this cycle
   logic wr_ctrl;                  // Control register write
   logic wr_flash;                 // Flash access write
   logic [31:0] rd_word;           // Read mux output
   logic [31:0] ctrl_word;         // Control register image
   logic [31:0] flash_word;        // Flash access image

   ////////////////////////////////////////////////////////////////////////////
   // Address match, used by every decode
   function automatic logic addr_hit(input logic [11:0] addr, input logic [11:0] off);
      addr_hit = addr == off;
   endfunction

   assign wr_ctrl = reg_req_in.wr && addr_hit(reg_req_in.addr, `EEBB_OFF_CTRL);
   assign wr_flash = reg_req_in.wr && addr_hit(reg_req_in.addr, `EEBB_OFF_FLASH_ACC);

   ////////////////////////////////////////////////////////////////////////////
   // Automatic read engine
   eebb_auto_read eebb_auto_read_i (
      .ref_clk_in(ref_clk_in),
      .sys_rst_in(sys_rst_in),
      .halt_in(function_disable_in),
      .mem_do_in(mem_do_in),
      .pins_out(eng_pins),
      .busy_out(eng_busy),
      .done_out(eng_done),
      .present_out(eng_present),
      .sig_ok_out()
   );

   ////////////////////////////////////////////////////////////////////////////
   // Software pin bits and request
   always_ff @(posedge ref_clk_in) begin
      if (sys_rst_in) begin
         sw_pins_reg <= `EEBB_RST_PINS;
         req_reg <= 1'b0;
      end else if (wr_ctrl) begin
         // Bit 3 and the status bits are not writable
         sw_pins_reg.sk <= reg_req_in.wdata[`EEBB_BIT_SK];
         sw_pins_reg.cs <= reg_req_in.wdata[`EEBB_BIT_CS];
         sw_pins_reg.di <= reg_req_in.wdata[`EEBB_BIT_DI];
         req_reg <= reg_req_in.wdata[`EEBB_BIT_REQ];
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Sticky failure after function disable during bit-bang
   always_ff @(posedge ref_clk_in) begin
      if (sys_rst_in) begin
         dead_reg <= 1'b0;
      end else if (function_disable_in && (req_reg || gnt_reg)) begin
         dead_reg <= 1'b1;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Grant arbitration against the engine
   always_comb begin
      if (dead_reg || function_disable_in) begin
         gnt_next = 1'b0;
      end else if (!req_reg) begin
         gnt_next = 1'b0;
      end else if (!eng_busy) begin
         gnt_next = 1'b1;
      end else begin
         gnt_next = gnt_reg;
      end
   end

   always_ff @(posedge ref_clk_in) begin
      if (sys_rst_in) begin
         gnt_reg <= 1'b0;
      end else begin
         gnt_reg <= gnt_next;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Memory pin mux: low on disable or failure, software while granted, engine otherwise
   always_ff @(posedge ref_clk_in) begin
      if (sys_rst_in) begin
         mem_pins_out <= `EEBB_RST_PINS;
      end else if (dead_reg || function_disable_in) begin
         mem_pins_out <= `EEBB_RST_PINS;
      end else if (gnt_reg) begin
         mem_pins_out <= sw_pins_reg;
      end else begin
         mem_pins_out <= eng_pins;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Data-out sampled every internal clock
   always_ff @(posedge ref_clk_in) begin
      if (sys_rst_in) begin
         do_sample_reg <= 1'b0;
      end else begin
         do_sample_reg <= mem_do_in;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Flash write-enable field
   always_ff @(posedge ref_clk_in) begin
      if (sys_rst_in) begin
         fwe_reg <= `EEBB_RST_FWE;
      end else if (wr_ctrl && swacc_reg) begin
         // Barred code leaves the field unchanged
         if (reg_req_in.wdata[`EEBB_FWE_HI:`EEBB_FWE_LO] != `EEBB_FWE_BAD) begin
            fwe_reg <= reg_req_in.wdata[`EEBB_FWE_HI:`EEBB_FWE_LO];
         end
      end
   end

   // Write enable to the flash path
   always_ff @(posedge ref_clk_in) begin
      if (sys_rst_in) begin
         flash_write_en_out <= 1'b0;
      end else begin
         flash_write_en_out <= fwe_reg == `EEBB_FWE_EN;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Flash access register: software access enable and erase bit
   always_ff @(posedge ref_clk_in) begin
      if (sys_rst_in) begin
         swacc_reg <= 1'b0;
      end else if (wr_flash) begin
         swacc_reg <= reg_req_in.wdata[`EEBB_BIT_SWACC];
      end
   end

   // Erase only with erase code, serial flash, and erase bit
   assign erase_fire = erase_reg && (fwe_reg == `EEBB_FWE_ERASE) &&
                       flash_is_serial_in && !dead_reg;

   always_ff @(posedge ref_clk_in) begin
      if (sys_rst_in) begin
         erase_reg <= 1'b0;
      end else if (wr_flash) begin
         // A fresh write wins over the self-clear
         erase_reg <= reg_req_in.wdata[`EEBB_BIT_ERASE];
      end else if (erase_fire) begin
         erase_reg <= 1'b0;
      end
   end

   // One-cycle erase command
   always_ff @(posedge ref_clk_in) begin
      if (sys_rst_in) begin
         flash_erase_out <= 1'b0;
      end else begin
         flash_erase_out <= erase_fire;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Presence and auto read done flags
   always_ff @(posedge ref_clk_in) begin
      if (sys_rst_in) begin
         pres_reg <= `EEBB_RST_PRES;
      end else begin
         pres_reg <= eng_present;
      end
   end

   always_ff @(posedge ref_clk_in) begin
      if (sys_rst_in) begin
         autord_reg <= 1'b0;
      end else if (eng_done) begin
         autord_reg <= 1'b1;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Interrupt status, enable and output
   always_comb begin
      irq_event = '0;
      irq_event[`EEBB_IRQ_GNT] = gnt_next && !gnt_reg;
      irq_event[`EEBB_IRQ_AUTORD] = eng_done;
      irq_event[`EEBB_IRQ_ERASE] = erase_fire;
   end

   assign irq_clr = (reg_req_in.wr && addr_hit(reg_req_in.addr, `EEBB_OFF_IRQ_CLR)) ?
                    reg_req_in.wdata[`EEBB_IRQ_W-1:0] : '0;

   // Set wins over a clear in the same cycle
   always_ff @(posedge ref_clk_in) begin
      if (sys_rst_in) begin
         irq_stat_reg <= '0;
      end else begin
         irq_stat_reg <= (irq_stat_reg & ~irq_clr) | irq_event;
      end
   end

   always_ff @(posedge ref_clk_in) begin
      if (sys_rst_in) begin
         irq_en_reg <= '0;
      end else if (reg_req_in.wr && addr_hit(reg_req_in.addr, `EEBB_OFF_IRQ_EN)) begin
         irq_en_reg <= reg_req_in.wdata[`EEBB_IRQ_W-1:0];
      end
   end

   assign irq_out = |(irq_stat_reg & irq_en_reg);

   ////////////////////////////////////////////////////////////////////////////
   // Register images and read mux
   always_comb begin
      ctrl_word = `EEBB_RST_WORD;
      ctrl_word[`EEBB_BIT_SK] = sw_pins_reg.sk;
      ctrl_word[`EEBB_BIT_CS] = sw_pins_reg.cs;
      ctrl_word[`EEBB_BIT_DI] = sw_pins_reg.di;
      ctrl_word[`EEBB_BIT_DO] = do_sample_reg;
      ctrl_word[`EEBB_FWE_HI:`EEBB_FWE_LO] = fwe_reg;
      ctrl_word[`EEBB_BIT_REQ] = req_reg;
      ctrl_word[`EEBB_BIT_GNT] = gnt_reg;
      ctrl_word[`EEBB_BIT_PRES] = pres_reg;
      ctrl_word[`EEBB_BIT_AUTORD] = autord_reg;
   end

   always_comb begin
      flash_word = `EEBB_RST_WORD;
      flash_word[`EEBB_BIT_SWACC] = swacc_reg;
      flash_word[`EEBB_BIT_ERASE] = erase_reg;
   end

   always_comb begin
      rd_word = `EEBB_RST_WORD;
      if (addr_hit(reg_req_in.addr, `EEBB_OFF_CTRL)) begin
         rd_word = ctrl_word;
      end else if (addr_hit(reg_req_in.addr, `EEBB_OFF_FLASH_ACC)) begin
         rd_word = flash_word;
      end else if (addr_hit(reg_req_in.addr, `EEBB_OFF_IRQ_STAT)) begin
         rd_word[`EEBB_IRQ_W-1:0] = irq_stat_reg;
      end else if (addr_hit(reg_req_in.addr, `EEBB_OFF_IRQ_EN)) begin
         rd_word[`EEBB_IRQ_W-1:0] = irq_en_reg;
      end else begin
         // Clear register and unmapped addresses read zero
         rd_word = `EEBB_RST_WORD;
      end
   end

   // Read data valid only in the cycle after the strobe
   always_ff @(posedge ref_clk_in) begin
      if (sys_rst_in) begin
         reg_rdata_out <= `EEBB_RST_WORD;
      end else if (reg_req_in.rd) begin
         reg_rdata_out <= rd_word;
      end else begin
         reg_rdata_out <= `EEBB_RST_WORD;
      end
   end

endmodule

// ### hw/eebb_pkg.sv
// Types shared by the EEPROM bit-bang control files
package eebb_pkg;

   // Register port request bundle
   typedef struct packed {
      logic [11:0] addr;  // Byte address
      logic [31:0] wdata; // Write data
      logic wr;           // Write strobe
      logic rd;           // Read strobe
   } eebb_reg_req_t;

   // Serial memory output pins
   typedef struct packed {
      logic sk; // Serial clock
      logic cs; // Chip select
      logic di; // Data into memory
   } eebb_pins_t;

   // Automatic read engine states
   typedef enum logic [2:0] {
      AR_START,
      AR_CMD,
      AR_ACK,
      AR_DATA,
      AR_DONE
   } eebb_ar_state_t;

endpackage

// ### hw/eebb_regs.svh
// Register offsets, field positions, reset values and counts of the EEPROM bit-bang control
`ifndef EEBB_REGS_SVH
`define EEBB_REGS_SVH

////////////////////////////////////////////////////////////////////////////////
// Register byte offsets
`define EEBB_OFF_CTRL 12'h010
`define EEBB_OFF_FLASH_ACC 12'h01C
`define EEBB_OFF_IRQ_STAT 12'h020
`define EEBB_OFF_IRQ_CLR 12'h024
`define EEBB_OFF_IRQ_EN 12'h028

////////////////////////////////////////////////////////////////////////////////
// Control register field positions
`define EEBB_BIT_SK 0
`define EEBB_BIT_CS 1
`define EEBB_BIT_DI 2
`define EEBB_BIT_DO 3
`define EEBB_FWE_LO 4
`define EEBB_FWE_HI 5
`define EEBB_BIT_REQ 6
`define EEBB_BIT_GNT 7
`define EEBB_BIT_PRES 8
`define EEBB_BIT_AUTORD 9

// Flash access register field positions
`define EEBB_BIT_SWACC 7
`define EEBB_BIT_ERASE 31

////////////////////////////////////////////////////////////////////////////////
// Flash write-enable codes
`define EEBB_FWE_ERASE 2'h0
`define EEBB_FWE_DIS 2'h1
`define EEBB_FWE_EN 2'h2
`define EEBB_FWE_BAD 2'h3

// Reset values
`define EEBB_RST_FWE 2'h1
`define EEBB_RST_PRES 1'h1
`define EEBB_RST_PINS 3'h0
`define EEBB_RST_WORD 32'h0000_0000

////////////////////////////////////////////////////////////////////////////////
// Interrupt status bit positions
`define EEBB_IRQ_GNT 0
`define EEBB_IRQ_AUTORD 1
`define EEBB_IRQ_ERASE 2
`define EEBB_IRQ_W 3

////////////////////////////////////////////////////////////////////////////////
// Automatic read engine
`define EEBB_SK_DIV 8'h0A
`define EEBB_CMD_BITS 5'h08
`define EEBB_DATA_BITS 5'h10
`define EEBB_READ_CMD 8'h03
`define EEBB_SIG_HI 15
`define EEBB_SIG_LO 14
`define EEBB_SIG_VALID 2'h1

`endif
